//--- rtl/crc_ladder_ctrl.sv
// Ladder control stage: registered drive of the analog ladder controls
`timescale 1ns/100ps
`default_nettype none
module crc_ladder_ctrl
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register fields
   input wire logic [7:0] ref_ctrl,
   input wire logic [2:0] comparator_mode_field,
   // Ladder controls
   output logic ladder_power_on,
   output logic reference_pin_connect,
   output logic range_select,
   output logic [3:0] tap_code,
   output logic reference_to_comparators
);
   import crc_pkg::*;
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic power;
      logic pin;
      logic range;
      logic [3:0] tap;
      logic route;
   } crc_lad_type;
   crc_lad_type st_r;
   crc_lad_type st_nxt;
   // Next ladder controls follow the register fields
   always_comb
   begin
      st_nxt.power = ref_ctrl[CRC_POWER_BIT];
      st_nxt.pin = ref_ctrl[CRC_PIN_BIT];
      st_nxt.range = ref_ctrl[CRC_RANGE_BIT];
      st_nxt.tap = ref_ctrl[CRC_TAP_MSB:0];
      st_nxt.route = (comparator_mode_field == CRC_MODE_REF);
   end
   // Register the controls
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign ladder_power_on = st_r.power;
   assign reference_pin_connect = st_r.pin;
   assign range_select = st_r.range;
   assign tap_code = st_r.tap;
   assign reference_to_comparators = st_r.route;
endmodule // crc_ladder_ctrl
`default_nettype wire

//--- rtl/crc_pkg.sv
// Package: register map, field layout and reset values of the reference control block
`default_nettype none
package crc_pkg;
   // ------------------------------------------------------------
   // Register offsets (register indexes) and their byte addresses on the register bus
   // ------------------------------------------------------------
   localparam logic [7:0] CRC_COMP_CTRL_OFS = 8'h9c; // Comparator control
   localparam logic [7:0] CRC_REF_CTRL_OFS = 8'h9d; // Reference control index
   localparam logic [11:0] CRC_COMP_CTRL_ADDR = 12'h270; // Index times four
   localparam logic [11:0] CRC_REF_CTRL_ADDR = 12'h274; // Index times four
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CRC_POWER_BIT = 7; // Ladder power
   localparam int CRC_PIN_BIT = 6; // Pin connect
   localparam int CRC_RANGE_BIT = 5; // Range select
   localparam int CRC_UNUSED_BIT = 4; // Unimplemented
   localparam int CRC_TAP_MSB = 3; // Tap code high bit
   localparam int CRC_MODE_MSB = 2; // Comparator mode high bit
   // ------------------------------------------------------------
   // Reset values and masks
   // ------------------------------------------------------------
   localparam logic [7:0] CRC_REF_RESET = 8'h00; // Reference control reset
   localparam logic [7:0] CRC_COMP_RESET = 8'h07; // Comparator control reset
   localparam logic [7:0] CRC_REF_WMASK = 8'hef; // Writable reference bits
   localparam logic [7:0] CRC_COMP_WMASK = 8'h3f; // Writable comparator bits
   localparam logic [2:0] CRC_MODE_REF = 3'h2; // Mode that routes the reference
   // AXI responses
   localparam logic [1:0] CRC_RESP_OKAY = 2'h0; // Okay
   localparam logic [1:0] CRC_RESP_SLVERR = 2'h2; // Unmapped address
endpackage
`default_nettype wire

//--- rtl/crc_top.sv
// Top: AXI4-Lite register slave for the comparator reference control
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Power bit seven powers the ladder
// - Bit six connects reference to the pin
// - Range one: zero to 0.625, supply/24 steps
// - Range zero: quarter to 0.72, supply/32
// - Low four bits hold tap code 0-15
// - Bit four ignores writes, reads zero
// - Register at 9Dh, read/write, reset zero
// - Sixteen-tap ladder, two ranges, power-down
// - Route reference only in mode 010
module crc_top
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Comparator outputs (read-only status)
   input wire logic [1:0] comparator_out,
   // Ladder controls
   output logic ladder_power_on,
   output logic reference_pin_connect,
   output logic range_select,
   output logic [3:0] tap_code,
   output logic reference_to_comparators
);
   import crc_pkg::*;
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic aw_held; // Write address captured
      logic [11:0] aw_addr; // Captured write address
      logic w_held; // Write data captured
      logic [7:0] w_data; // Captured low byte
      logic w_strb0; // Captured lane zero strobe
      logic bvalid; // Write response pending
      logic [1:0] bresp; // Write response code
      logic rvalid; // Read data pending
      logic [31:0] rdata; // Read data
      logic [1:0] rresp; // Read response code
      logic [7:0] ref_ctrl; // Reference control
      logic [5:0] comp_ctrl; // Comparator control writable part
      logic [1:0] cmp_s1; // Comparator sync stage 1
      logic [1:0] cmp_s2; // Comparator sync stage 2
      logic [1:0] cmp_s3; // Comparator sync stage 3
      logic [1:0] cmp_out; // Agreed comparator outputs
   } crc_top_type;
   crc_top_type st_r;
   crc_top_type st_nxt;
   // Address decode: 0 none, 1 comparator control, 2 reference control
   function automatic logic [1:0] crc_decode(input logic [11:0] addr);
      if (addr == CRC_COMP_CTRL_ADDR)
         crc_decode = 2'h1;
      else if (addr == CRC_REF_CTRL_ADDR)
         crc_decode = 2'h2;
      else
         crc_decode = 2'h0;
   endfunction
   logic [11:0] wr_addr; // Address of a write in flight
   logic [7:0] wr_byte; // Byte of a write in flight
   logic wr_lane0; // Lane zero enabled
   logic wr_fire; // Both halves present
   logic [7:0] comp_view; // Comparator control as read
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      // Comparator outputs: change counts when stages two and three agree
      st_nxt.cmp_s1 = comparator_out;
      st_nxt.cmp_s2 = st_r.cmp_s1;
      st_nxt.cmp_s3 = st_r.cmp_s2;
      if (st_r.cmp_s2 == st_r.cmp_s3)
      begin
         st_nxt.cmp_out = st_r.cmp_s3;
      end
      // Capture write address and data independently
      if (s_axi_awvalid && s_axi_awready)
      begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = s_axi_wdata[7:0];
         st_nxt.w_strb0 = s_axi_wstrb[0];
      end
      // Perform the write once both halves are present
      wr_addr = st_r.aw_held ? st_r.aw_addr : s_axi_awaddr;
      wr_byte = st_r.w_held ? st_r.w_data : s_axi_wdata[7:0];
      wr_lane0 = st_r.w_held ? st_r.w_strb0 : s_axi_wstrb[0];
      wr_fire = (st_r.aw_held || (s_axi_awvalid && s_axi_awready))
         && (st_r.w_held || (s_axi_wvalid && s_axi_wready)) && !st_r.bvalid;
      if (wr_fire)
      begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = CRC_RESP_OKAY;
         unique case (crc_decode(wr_addr))
            2'h1:
            begin
               // Comparator control: outputs are read-only
               if (wr_lane0)
                  st_nxt.comp_ctrl = wr_byte[5:0] & CRC_COMP_WMASK[5:0];
            end
            2'h2:
            begin
               // Reference control: bit four never stored
               if (wr_lane0)
                  st_nxt.ref_ctrl = wr_byte & CRC_REF_WMASK;
            end
            default:
            begin
               // Unmapped address
               st_nxt.bresp = CRC_RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
      end
      // Read path
      comp_view = {st_r.cmp_out, st_r.comp_ctrl};
      if (s_axi_arvalid && s_axi_arready)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = CRC_RESP_OKAY;
         unique case (crc_decode(s_axi_araddr))
            2'h1:
               st_nxt.rdata = {24'h00_0000, comp_view};
            2'h2:
               st_nxt.rdata = {24'h00_0000, st_r.ref_ctrl & CRC_REF_WMASK};
            default:
            begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = CRC_RESP_SLVERR;
            end
         endcase
      end
      else if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
   end
   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
         st_r.ref_ctrl <= CRC_REF_RESET;
         st_r.comp_ctrl <= CRC_COMP_RESET[5:0];
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   // Handshake outputs
   assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   // ------------------------------------------------------------
   // Ladder control stage
   // ------------------------------------------------------------
   crc_ladder_ctrl crc_ladder_ctrl_inst
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .ref_ctrl(st_r.ref_ctrl),
      .comparator_mode_field(st_r.comp_ctrl[CRC_MODE_MSB:0]),
      .ladder_power_on(ladder_power_on),
      .reference_pin_connect(reference_pin_connect),
      .range_select(range_select),
      .tap_code(tap_code),
      .reference_to_comparators(reference_to_comparators)
   );
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   power_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 ladder_power_on == $past(st_r.ref_ctrl[7]))
      else $error("ladder power does not follow bit seven");
   pin_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 reference_pin_connect == $past(st_r.ref_ctrl[6]))
      else $error("pin connect does not follow bit six");
   range_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.ref_ctrl[5] |=> range_select)
      else $error("low range not selected");
   range_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.ref_ctrl[5] |=> !range_select)
      else $error("high range not selected");
   tap_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 tap_code == $past(st_r.ref_ctrl[3:0]))
      else $error("tap code mismatch");
   // Every reference read shows bit four and the upper bits as zero
   bit_four_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && crc_decode(s_axi_araddr) == 2'h2
         |=> !s_axi_rdata[CRC_UNUSED_BIT] && s_axi_rdata[31:8] == 24'h00_0000)
      else $error("bit four or upper bits read nonzero");
   // Reset loads both registers with their reset values
   reset_clear_a: assert property (@(posedge aclk)
      !aresetn |=> st_r.ref_ctrl == CRC_REF_RESET && st_r.comp_ctrl == CRC_COMP_RESET[5:0])
      else $error("reset values wrong");
   // Reference reaches the comparators only in the routing mode
   route_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 reference_to_comparators == ($past(st_r.comp_ctrl[2:0]) == CRC_MODE_REF))
      else $error("reference routed in wrong mode");
   // A reference write reaches the ladder tap two edges after it is taken
   write_next_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_lane0 && wr_addr == CRC_REF_CTRL_ADDR
         |-> ##2 tap_code == $past(wr_byte[3:0], 2))
      else $error("write not applied on time");
   // Stored reference value keeps every written bit except bit four
   ref_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_lane0 && crc_decode(wr_addr) == 2'h2
         |=> st_r.ref_ctrl == {$past(wr_byte[7:5]), 1'b0, $past(wr_byte[3:0])})
      else $error("reference write stored wrongly");
   // Comparator control keeps its low six written bits
   comp_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_lane0 && crc_decode(wr_addr) == 2'h1
         |=> st_r.comp_ctrl == $past(wr_byte[5:0]))
      else $error("comparator control write stored wrongly");
   // A write with lane zero off changes no register
   lane_masked_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && !wr_lane0 |=> $stable(st_r.ref_ctrl) && $stable(st_r.comp_ctrl))
      else $error("masked write changed a register");
   // ------------------------------------------------------------
   // Bus handshake checks
   // ------------------------------------------------------------
   // Unmapped write: error response, no register change
   unmapped_wr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && crc_decode(wr_addr) == 2'h0
         |=> s_axi_bresp == CRC_RESP_SLVERR && $stable(st_r.ref_ctrl)
         && $stable(st_r.comp_ctrl))
      else $error("unmapped write not refused");
   // Unmapped read: error response with zero data
   unmapped_rd_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && crc_decode(s_axi_araddr) == 2'h0
         |=> s_axi_rresp == CRC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   // Each answer comes one cycle after its request is taken
   write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   // An answer and its payload stand until the master takes it
   bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");
   // No new request is taken while an answer of its own kind (write or read) is pending
   write_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   read_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   // Comparator status moves only when stages two and three agree
   cmp_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.cmp_s2 == st_r.cmp_s3 |=> st_r.cmp_out == $past(st_r.cmp_s3))
      else $error("comparator status not synchronised");
endmodule // crc_top
`default_nettype wire

//--- tb/comparator_reference_control_tb_top.sv
// Testbench: AXI4-Lite register tests of the comparator reference control block
`timescale 1ns/100ps
`default_nettype none
module comparator_reference_control_tb_top;
   import crc_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic aclk = 1'b0; // Bench clock
   logic aresetn = 1'b0; // Synchronous reset
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] comparator_out = 2'h0; // Comparator status inputs
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic ladder_power_on, reference_pin_connect, range_select, reference_to_comparators;
   logic [3:0] tap_code;
   int num_errors = 0; // Mismatch count
   int tests_run = 0; // Comparison count
   logic [1:0] resp; // Last response code
   logic [31:0] rd; // Last read data
   logic [7:0] v; // Pattern under test
   // Device under test
   crc_top crc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .comparator_out(comparator_out),
      .ladder_power_on(ladder_power_on), .reference_pin_connect(reference_pin_connect),
      .range_select(range_select), .tap_code(tap_code),
      .reference_to_comparators(reference_to_comparators));
   // Clock: 20 ns period
   initial
   begin
      forever #10 aclk = ~aclk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Verdict and end of run
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Wait-limit failure
   task automatic give_up();
      num_errors++;
      $display("ERROR t=%0t bus handshake timed out", $time);
      final_report();
   endtask
   // AXI4-Lite write; flags sampled mid-cycle, released after the taking edge
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_t, w_t, b_t;
      int n;
      b_t = 1'b0;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_t && n < 50)
      begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid && s_axi_bready;
         resp = s_axi_bresp;
         n++;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (b_t) s_axi_bready <= 1'b0;
      end
      if (!b_t) give_up();
   endtask
   // AXI4-Lite read
   task automatic axi_read(input logic [11:0] a);
      logic ar_t, r_t;
      int n;
      r_t = 1'b0;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_t && n < 50)
      begin
         @(negedge aclk);
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid && s_axi_rready;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         n++;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
         if (r_t) s_axi_rready <= 1'b0;
      end
      if (!r_t) give_up();
   endtask
   // Ladder drive against a reference control value
   task automatic chk_ladder(input logic [7:0] e);
      @(negedge aclk);
      chk({24'h0, ladder_power_on, reference_pin_connect, range_select, 1'b0, tap_code},
         {24'h0, e & CRC_REF_WMASK});
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values
      axi_read(CRC_REF_CTRL_ADDR);
      chk(rd, 32'h0000_0000);
      chk({30'h0, resp}, {30'h0, CRC_RESP_OKAY});
      axi_read(CRC_COMP_CTRL_ADDR);
      chk(rd, {24'h0, CRC_COMP_RESET});
      chk_ladder(8'h00);
      // Every tap code, both ranges, bit four always written high
      for (int i = 0; i < 16; i++)
      begin
         v = {i[0], i[1], i[2], 1'b1, i[3:0]};
         axi_write(CRC_REF_CTRL_ADDR, {24'h0, v}, 4'h1);
         chk({30'h0, resp}, {30'h0, CRC_RESP_OKAY});
         chk_ladder(v);
         axi_read(CRC_REF_CTRL_ADDR);
         chk(rd, {24'h0, v & 8'hef});
      end
      // Lane zero masked: no change
      axi_write(CRC_REF_CTRL_ADDR, 32'h0000_0000, 4'he);
      chk({30'h0, resp}, {30'h0, CRC_RESP_OKAY});
      // Unmapped write and read: error, no change
      axi_write(12'h278, 32'h0000_0000, 4'h1);
      chk({30'h0, resp}, {30'h0, CRC_RESP_SLVERR});
      axi_read(12'h278);
      chk(rd, 32'h0000_0000);
      chk({30'h0, resp}, {30'h0, CRC_RESP_SLVERR});
      axi_read(CRC_REF_CTRL_ADDR);
      chk(rd, 32'h0000_00ef);
      // Every comparator mode; status bits read-only
      comparator_out <= 2'h2;
      for (int m = 0; m < 8; m++)
      begin
         axi_write(CRC_COMP_CTRL_ADDR, {24'h0, 5'h1f, m[2:0]}, 4'h1);
         @(negedge aclk);
         chk({31'h0, reference_to_comparators}, {31'h0, m == 2});
      end
      axi_read(CRC_COMP_CTRL_ADDR);
      chk(rd, 32'h0000_00bf);
      // Reset in mid-run clears the controls
      @(posedge aclk);
      aresetn <= 1'b0;
      comparator_out <= 2'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk_ladder(8'h00);
      chk({31'h0, reference_to_comparators}, 32'h0);
      axi_read(CRC_REF_CTRL_ADDR);
      chk(rd, 32'h0000_0000);
      axi_read(CRC_COMP_CTRL_ADDR);
      chk(rd, 32'h0000_0007);
      final_report();
   end
endmodule // comparator_reference_control_tb_top
`default_nettype wire
